// ==== rtl/flash_prot_consts.vh ====
// Constants for the flash program/erase protection block
`ifndef FLASH_PROT_CONSTS_VH
`define FLASH_PROT_CONSTS_VH

// Field positions inside the first control register
`define FC1_PROG_BIT      0
`define FC1_ERASE_BIT     1
`define FC1_PVERIFY_BIT   2
`define FC1_EVERIFY_BIT   3
`define FC1_SWPERMIT_BIT  6

// Field position of the error flag inside the second control register
`define FC2_ERRFLAG_BIT   7

// Register widths
`define FC_WIDTH          8
`define EBS1_WIDTH        8
`define EBS2_WIDTH        4
`define BLOCK_COUNT       12

// Initial values
`define FC1_RESET         8'h00
`define EBS1_RESET        8'h00
`define EBS2_RESET        4'h0
`define EBS2_ALL_CLEAR    4'h0
`define EBS1_ALL_CLEAR    8'h00

// Read select codes
`define SEL_WIDTH         2
`define SEL_FC1           2'h0
`define SEL_FC2           2'h1
`define SEL_EBS1          2'h2
`define SEL_EBS2          2'h3

// Value returned for control register reads in the mask-ROM variant (arbitrary)
`define MASK_ROM_READ     8'hA5

`endif

// ==== rtl/erase_block_gate.v ====
// Per-block erase enable decode for the flash erase block selects
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_consts.vh"

module erase_block_gate (
    input  wire                     sys_clk,
    input  wire                     rst_n,
    input  wire                     eraseActive,
    input  wire [`EBS1_WIDTH-1:0]   ebsFirst,
    input  wire [`EBS2_WIDTH-1:0]   ebsSecond,
    output wire                     anyBlock,
    output reg  [`BLOCK_COUNT-1:0]  blockErase_r
);

    wire [`BLOCK_COUNT-1:0] sel;

    assign sel      = {ebsSecond, ebsFirst};
    // All zeros in both selects protects every block
    assign anyBlock = (ebsFirst != `EBS1_ALL_CLEAR) || (ebsSecond != `EBS2_ALL_CLEAR); // [RULE7]

    // ------------------------------------------------------------
    // Per-block enables
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `BLOCK_COUNT; i = i + 1) begin : gBlock
            always @(posedge sys_clk) begin
                if (!rst_n) begin
                    blockErase_r[i] <= 1'b0;
                end else begin
                    blockErase_r[i] <= eraseActive & sel[i]; // [RULE6]
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ==== rtl/flash_program_erase_protection.v ====
// Flash program/erase protection: hardware, software and error protection
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_consts.vh"

// How it works
// RULE1: No interrupts, NMI too, while programming, erasing, booting
// RULE2: Write-permit pin high clears registers, protects flash
// RULE3: Any reset or standby clears registers, protects
// RULE4: Software permit bit zero protects all blocks
// RULE5: Request bits ignored under software protection
// RULE6: Erase selects gate erase per block only
// RULE7: All-zero erase selects protect every block
// RULE8: RAM overlay active protects all blocks
// RULE9: Flash read while busy sets error flag
// RULE10: Non-reset exception while busy sets error flag
// RULE11: Sleep while busy sets error flag
// RULE12: Error keeps registers, aborts program/erase immediately
// RULE13: Error protection blocks program/erase restart
// RULE14: Error protection still allows verify modes
// RULE15: Only power-on reset clears error protection
// RULE16: Flash access on after reset; standby bit disables
// RULE17: Mask-ROM variant reads control registers undefined
// RULE18: Program only while program request bit held
// RULE19: Software selects one block per erase
// RULE20: Error flag readable, stays set until power-on
module flash_program_erase_protection #(
    parameter MASK_ROM_VARIANT = 0
) (
    input  wire                     sys_clk,
    input  wire                     rst_n,
    input  wire                     flash_write_permit_pin,
    input  wire                     systemResetReq,
    input  wire                     standbyMode,
    input  wire                     moduleStandby,
    input  wire                     ram_overlay_active,
    input  wire                     bootRunning,
    input  wire                     flashReadAccess,
    input  wire                     exceptionStart,
    input  wire                     sleepExec,
    input  wire                     irqIn,
    input  wire                     nmiIn,
    input  wire                     fc1WrEn,
    input  wire [`FC_WIDTH-1:0]     fc1WrData,
    input  wire                     ebs1WrEn,
    input  wire [`EBS1_WIDTH-1:0]   ebs1WrData,
    input  wire                     ebs2WrEn,
    input  wire [`EBS2_WIDTH-1:0]   ebs2WrData,
    input  wire [`SEL_WIDTH-1:0]    regRdSel,
    output reg  [`FC_WIDTH-1:0]     regRdData_r,
    output reg                      programActive_r,
    output reg                      eraseActive_r,
    output wire [`BLOCK_COUNT-1:0]  blockErase_r,
    output reg                      programVerify_r,
    output reg                      eraseVerify_r,
    output reg                      errorProtect_r,
    output reg                      irqOut_r,
    output reg                      nmiOut_r,
    output reg                      flashAccessEn_r
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    reg  [`FC_WIDTH-1:0]    flash_control_first_r;
    reg  [`FC_WIDTH-1:0]    flash_control_first_nxt;
    reg  [`EBS1_WIDTH-1:0]  erase_block_select_first_r;
    reg  [`EBS1_WIDTH-1:0]  erase_block_select_first_nxt;
    reg  [`EBS2_WIDTH-1:0]  erase_block_select_second_r;
    reg  [`EBS2_WIDTH-1:0]  erase_block_select_second_nxt;
    reg                     flash_error_flag_r;
    reg                     flash_error_flag_nxt;

    reg                     programActive_nxt;
    reg                     eraseActive_nxt;
    reg                     programVerify_nxt;
    reg                     eraseVerify_nxt;
    reg  [`FC_WIDTH-1:0]    regRdData_nxt;

    wire [`FC_WIDTH-1:0]    flash_control_second;
    wire                    hwProtect;
    wire                    swProtect;
    wire                    busy;
    wire                    errDetect;
    wire                    anyBlock;
    wire                    programReq;
    wire                    eraseReq;
    wire                    software_write_permit;
    wire                    verifyAllowed;
    wire                    modeBlock;
    wire                    intMask;

    // ------------------------------------------------------------
    // Protection conditions
    // ------------------------------------------------------------
    // Pin, non-power-on reset (watchdog included) and standby all
    // force the initial state of the writable control registers.
    assign hwProtect = flash_write_permit_pin  // [RULE2]
                     | systemResetReq          // [RULE3]
                     | standbyMode;            // [RULE3]

    assign software_write_permit = flash_control_first_r[`FC1_SWPERMIT_BIT];

    assign swProtect = ~software_write_permit  // [RULE4]
                     | ram_overlay_active;     // [RULE8]

    assign programReq = flash_control_first_r[`FC1_PROG_BIT];
    assign eraseReq   = flash_control_first_r[`FC1_ERASE_BIT];

    assign busy = programActive_r | eraseActive_r;

    // Any of the three illegal events during an operation
    assign errDetect = busy & (flashReadAccess  // [RULE9]
                            | exceptionStart    // [RULE10]
                            | sleepExec);       // [RULE11]

    // Error flag occupies one bit of the second control register
    assign flash_control_second = {flash_error_flag_r,
                                   {(`FC_WIDTH-1){1'b0}}};

    // ------------------------------------------------------------
    // Mode gating
    // ------------------------------------------------------------
    // Any one protection kind is enough to refuse a mode entry
    assign modeBlock = swProtect                 // [RULE5]
                     | hwProtect                 // [RULE2]
                     | flash_error_flag_nxt;     // [RULE13]

    // Verify needs the permit bit but not a clean error state
    assign verifyAllowed = ~hwProtect & software_write_permit; // [RULE14]

    assign intMask = programActive_nxt | eraseActive_nxt | bootRunning; // [RULE1]

    // ------------------------------------------------------------
    // Erase block decode
    // ------------------------------------------------------------
    // Decode assumes a single selected block per erase; several set
    // bits simply erase several blocks at once.
    erase_block_gate uBlockGate (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .eraseActive  (eraseActive_nxt),
        .ebsFirst     (erase_block_select_first_r),
        .ebsSecond    (erase_block_select_second_r),
        .anyBlock     (anyBlock),
        .blockErase_r (blockErase_r)
    ); // [RULE19]

    // ------------------------------------------------------------
    // Control register next values
    // ------------------------------------------------------------
    always @* begin
        flash_control_first_nxt       = flash_control_first_r;
        erase_block_select_first_nxt  = erase_block_select_first_r;
        erase_block_select_second_nxt = erase_block_select_second_r;

        if (hwProtect) begin
            flash_control_first_nxt       = `FC1_RESET;  // [RULE2]
            erase_block_select_first_nxt  = `EBS1_RESET; // [RULE3]
            erase_block_select_second_nxt = `EBS2_RESET; // [RULE3]
        end else begin
            // Writes are still taken in error protection; the
            // settings are kept, only the modes are blocked.
            if (fc1WrEn) begin
                flash_control_first_nxt = fc1WrData;     // [RULE12]
            end
            if (ebs1WrEn) begin
                erase_block_select_first_nxt = ebs1WrData;
            end
            if (ebs2WrEn) begin
                erase_block_select_second_nxt = ebs2WrData;
            end
        end
    end

    // ------------------------------------------------------------
    // Error flag
    // ------------------------------------------------------------
    // Sticky: no write port and no other reset reaches it.
    always @* begin
        flash_error_flag_nxt = flash_error_flag_r;
        if (errDetect) begin
            flash_error_flag_nxt = 1'b1;                 // [RULE20]
        end
    end

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    always @* begin
        programActive_nxt = 1'b0;
        eraseActive_nxt   = 1'b0;

        // Program lasts only while the request bit is held
        if (programReq && !modeBlock) begin
            programActive_nxt = 1'b1;                    // [RULE18]
        end

        if (eraseReq && !modeBlock && anyBlock) begin
            eraseActive_nxt = 1'b1;                      // [RULE5]
        end

        // Error detected this cycle ends the mode at the next edge;
        // the flag itself prevents any later restart.
        if (errDetect) begin
            programActive_nxt = 1'b0;                    // [RULE12]
            eraseActive_nxt   = 1'b0;                    // [RULE12]
        end
        if (flash_error_flag_r) begin
            programActive_nxt = 1'b0;                    // [RULE13]
            eraseActive_nxt   = 1'b0;                    // [RULE13]
        end
    end

    // Verify modes ignore the error flag on purpose
    always @* begin
        programVerify_nxt = 1'b0;
        eraseVerify_nxt   = 1'b0;
        if (verifyAllowed) begin
            programVerify_nxt =
                flash_control_first_r[`FC1_PVERIFY_BIT]; // [RULE14]
            eraseVerify_nxt =
                flash_control_first_r[`FC1_EVERIFY_BIT]; // [RULE14]
        end
    end

    // ------------------------------------------------------------
    // Register read path
    // ------------------------------------------------------------
    always @* begin
        case (regRdSel)
            `SEL_FC1: begin
                regRdData_nxt = flash_control_first_r;
            end
            `SEL_FC2: begin
                regRdData_nxt = flash_control_second;    // [RULE20]
            end
            `SEL_EBS1: begin
                regRdData_nxt = erase_block_select_first_r;
            end
            `SEL_EBS2: begin
                regRdData_nxt = {{(`FC_WIDTH-`EBS2_WIDTH){1'b0}},
                                 erase_block_select_second_r};
            end
            default: begin
                regRdData_nxt = {`FC_WIDTH{1'b0}};
            end
        endcase
        // Without flash the control registers do not exist
        if (MASK_ROM_VARIANT != 0) begin
            regRdData_nxt = `MASK_ROM_READ;              // [RULE17]
        end
    end

    // ------------------------------------------------------------
    // Registers under power-on reset
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            flash_control_first_r       <= `FC1_RESET;
            erase_block_select_first_r  <= `EBS1_RESET;
            erase_block_select_second_r <= `EBS2_RESET;
        end else begin
            flash_control_first_r       <= flash_control_first_nxt;
            erase_block_select_first_r  <= erase_block_select_first_nxt;
            erase_block_select_second_r <= erase_block_select_second_nxt;
        end
    end

    // ------------------------------------------------------------
    // Error flag register
    // ------------------------------------------------------------
    // Kept apart: rst_n is the power-on reset, the only thing that
    // may clear it; system reset and standby act through hwProtect.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            flash_error_flag_r <= 1'b0;                  // [RULE15]
        end else begin
            flash_error_flag_r <= flash_error_flag_nxt;  // [RULE20]
        end
    end

    // ------------------------------------------------------------
    // Mode outputs
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            programActive_r <= 1'b0;
            eraseActive_r   <= 1'b0;
            programVerify_r <= 1'b0;
            eraseVerify_r   <= 1'b0;
        end else begin
            programActive_r <= programActive_nxt;
            eraseActive_r   <= eraseActive_nxt;
            programVerify_r <= programVerify_nxt;
            eraseVerify_r   <= eraseVerify_nxt;
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    // Read data lags the select by one cycle
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            errorProtect_r <= 1'b0;
            regRdData_r    <= {`FC_WIDTH{1'b0}};
        end else begin
            errorProtect_r <= flash_error_flag_nxt;      // [RULE15]
            regRdData_r    <= regRdData_nxt;
        end
    end

    // ------------------------------------------------------------
    // Interrupt gating
    // ------------------------------------------------------------
    // Uses next-state modes so the mask is in place on the same edge
    // that the operation starts; a request already pending at that
    // edge is held off, not lost, as the source keeps it asserted.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            irqOut_r <= 1'b0;
            nmiOut_r <= 1'b0;
        end else begin
            irqOut_r <= irqIn & ~intMask;                // [RULE1]
            nmiOut_r <= nmiIn & ~intMask;                // [RULE1]
        end
    end

    // ------------------------------------------------------------
    // Module standby
    // ------------------------------------------------------------
    // Standby blocks access only; no mode is aborted by it
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            flashAccessEn_r <= 1'b1;                     // [RULE16]
        end else begin
            flashAccessEn_r <= ~moduleStandby;           // [RULE16]
        end
    end

endmodule

`default_nettype wire

// ==== test/flash_prot_properties.sv ====
// Assertion checker for the flash program/erase protection block
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_consts.vh"

module flash_prot_properties (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        flash_write_permit_pin,
    input wire logic        systemResetReq,
    input wire logic        standbyMode,
    input wire logic        moduleStandby,
    input wire logic        ram_overlay_active,
    input wire logic        bootRunning,
    input wire logic        flashReadAccess,
    input wire logic        exceptionStart,
    input wire logic        sleepExec,
    input wire logic        irqIn,
    input wire logic        nmiIn,
    input wire logic        programActive_r,
    input wire logic        eraseActive_r,
    input wire logic [11:0] blockErase_r,
    input wire logic        errorProtect_r,
    input wire logic        irqOut_r,
    input wire logic        nmiOut_r,
    input wire logic        flashAccessEn_r
);
    wire busy   = programActive_r | eraseActive_r;
    wire fault  = flashReadAccess | exceptionStart | sleepExec;
    wire hwProt = flash_write_permit_pin | systemResetReq | standbyMode;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    // Mask follows next busy state, so it lines up with busy itself
    irq_gate_a:
        assert property ($past(rst_n) |-> irqOut_r == ($past(irqIn) && !$past(bootRunning) && !busy))
        else $error("irqOut_r gating wrong");
    nmi_gate_a:
        assert property ($past(rst_n) |-> nmiOut_r == ($past(nmiIn) && !$past(bootRunning) && !busy))
        else $error("nmiOut_r gating wrong");
    start_guard_a:
        assert property ($rose(busy) |-> !errorProtect_r && !$past(hwProt) && !$past(ram_overlay_active))
        else $error("program or erase started while protected");
    hw_clear_a:
        assert property (hwProt |=> !busy ##1 !busy)
        else $error("mode survived hardware protection");
    err_abort_a:
        assert property (busy && fault |=> errorProtect_r && !busy && blockErase_r == 12'h000)
        else $error("error not flagged or mode not aborted");
    err_cause_a:
        assert property ($rose(errorProtect_r) |-> $past(busy) && $past(fault))
        else $error("error flag set without cause");
    err_sticky_a:
        assert property (errorProtect_r |=> errorProtect_r)
        else $error("error flag cleared without power-on reset");
    blk_gate_a:
        assert property ((blockErase_r != 12'h000) == eraseActive_r)
        else $error("block erase enables disagree with erase mode");
    access_en_a:
        assert property ($past(rst_n) |-> flashAccessEn_r == !$past(moduleStandby))
        else $error("flash access enable wrong");

    cover property ($rose(programActive_r));
    cover property ($rose(eraseActive_r));
    cover property ($rose(errorProtect_r));
endmodule

bind flash_program_erase_protection flash_prot_properties u_props (
    .sys_clk, .rst_n, .flash_write_permit_pin, .systemResetReq, .standbyMode,
    .moduleStandby, .ram_overlay_active, .bootRunning, .flashReadAccess,
    .exceptionStart, .sleepExec, .irqIn, .nmiIn, .programActive_r, .eraseActive_r,
    .blockErase_r, .errorProtect_r, .irqOut_r, .nmiOut_r, .flashAccessEn_r
);
`default_nettype wire

// ==== test/flash_program_erase_protection_tb.sv ====
// Testbench for the flash program/erase protection block
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_consts.vh"

module flash_program_erase_protection_tb;
    logic        sys_clk, rst_n, pin, sysRst, stby, modStby, ram, boot, irqIn, nmiIn;
    logic        rdAcc, exc, slp, fc1We, ebs1We, ebs2We;
    logic        prog, ers, pv, ev, err, irqO, nmiO, accEn;
    logic [7:0]  fc1Wd, ebs1Wd, regRd, f, romRd;
    logic [3:0]  ebs2Wd;
    logic [1:0]  rdSel;
    logic [11:0] blk;
    int          num_errors = 0;
    int          num_checks = 0;

    typedef struct packed {
        logic [7:0]  f1;
        logic [7:0]  e1;
        logic [3:0]  e2;
        logic [2:0]  hw;   // standby, system reset, pin
        logic        ovl;
        logic        p;
        logic        e;
        logic [11:0] b;
    } row_t;
    row_t rows [12] = '{ // erase rows name at most one block each
        '{8'h41, 8'h00, 4'h0, 3'h0, 1'b0, 1'b1, 1'b0, 12'h000},
        '{8'h01, 8'h00, 4'h0, 3'h0, 1'b0, 1'b0, 1'b0, 12'h000},
        '{8'h02, 8'h01, 4'h0, 3'h0, 1'b0, 1'b0, 1'b0, 12'h000},
        '{8'h42, 8'h01, 4'h0, 3'h0, 1'b0, 1'b0, 1'b1, 12'h001},
        '{8'h42, 8'h00, 4'h8, 3'h0, 1'b0, 1'b0, 1'b1, 12'h800},
        '{8'h42, 8'h00, 4'h0, 3'h0, 1'b0, 1'b0, 1'b0, 12'h000},
        '{8'h41, 8'hFF, 4'hF, 3'h0, 1'b0, 1'b1, 1'b0, 12'h000},
        '{8'h41, 8'h00, 4'h0, 3'h1, 1'b0, 1'b0, 1'b0, 12'h000},
        '{8'h42, 8'h01, 4'h0, 3'h2, 1'b0, 1'b0, 1'b0, 12'h000},
        '{8'h41, 8'h00, 4'h0, 3'h4, 1'b0, 1'b0, 1'b0, 12'h000},
        '{8'h41, 8'h00, 4'h0, 3'h0, 1'b1, 1'b0, 1'b0, 12'h000},
        '{8'h42, 8'h10, 4'h0, 3'h0, 1'b1, 1'b0, 1'b0, 12'h000}
    };

    flash_program_erase_protection u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .flash_write_permit_pin(pin),
        .systemResetReq(sysRst), .standbyMode(stby), .moduleStandby(modStby),
        .ram_overlay_active(ram), .bootRunning(boot), .flashReadAccess(rdAcc),
        .exceptionStart(exc), .sleepExec(slp), .irqIn(irqIn), .nmiIn(nmiIn),
        .fc1WrEn(fc1We), .fc1WrData(fc1Wd), .ebs1WrEn(ebs1We), .ebs1WrData(ebs1Wd),
        .ebs2WrEn(ebs2We), .ebs2WrData(ebs2Wd), .regRdSel(rdSel), .regRdData_r(regRd),
        .programActive_r(prog), .eraseActive_r(ers), .blockErase_r(blk),
        .programVerify_r(pv), .eraseVerify_r(ev), .errorProtect_r(err),
        .irqOut_r(irqO), .nmiOut_r(nmiO), .flashAccessEn_r(accEn)
    );

    // Mask-ROM build: control register reads give a fixed filler
    flash_program_erase_protection #(.MASK_ROM_VARIANT(1)) u_dut_rom (
        .sys_clk(sys_clk), .rst_n(rst_n), .flash_write_permit_pin(pin),
        .systemResetReq(sysRst), .standbyMode(stby), .moduleStandby(modStby),
        .ram_overlay_active(ram), .bootRunning(boot), .flashReadAccess(rdAcc),
        .exceptionStart(exc), .sleepExec(slp), .irqIn(irqIn), .nmiIn(nmiIn),
        .fc1WrEn(fc1We), .fc1WrData(fc1Wd), .ebs1WrEn(ebs1We), .ebs1WrData(ebs1Wd),
        .ebs2WrEn(ebs2We), .ebs2WrData(ebs2Wd), .regRdSel(rdSel), .regRdData_r(romRd),
        .programActive_r(), .eraseActive_r(), .blockErase_r(),
        .programVerify_r(), .eraseVerify_r(), .errorProtect_r(),
        .irqOut_r(), .nmiOut_r(), .flashAccessEn_r()
    );

    // ------------------------------------------------------------------
    // Clock, tasks, watchdog
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Inputs move 10 ns after the edge so no race with the sampling edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask

    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] f1, input logic [7:0] e1, input logic [3:0] e2);
        fc1We = 1; ebs1We = 1; ebs2We = 1;
        fc1Wd = f1; ebs1Wd = e1; ebs2Wd = e2;
        step(1);
        fc1We = 0; ebs1We = 0; ebs2We = 0;
    endtask

    task automatic powerOn();
        rst_n = 0;
        step(5);
        rst_n = 1;
        step(1);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge sys_clk);
        num_errors++;
        $display("FAIL watchdog expected finish seen timeout");
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    initial begin
        rst_n = 0; pin = 0; sysRst = 0; stby = 0; modStby = 0; ram = 0; boot = 0;
        rdAcc = 0; exc = 0; slp = 0; irqIn = 1; nmiIn = 1; rdSel = `SEL_FC1;
        fc1We = 0; ebs1We = 0; ebs2We = 0; fc1Wd = 0; ebs1Wd = 0; ebs2Wd = 0;
        powerOn();
        for (int i = 0; i < 12; i++) begin
            ram = rows[i].ovl;
            wr(rows[i].f1, rows[i].e1, rows[i].e2);
            // Protection raised after the write lands, so clearing is seen
            {stby, sysRst, pin} = rows[i].hw;
            step(2);
            chk("program", prog, rows[i].p);
            chk("erase", ers, rows[i].e);
            chk("blocks", blk, rows[i].b);
            chk("irq", irqO, !(rows[i].p | rows[i].e));
            chk("fc1", regRd, rows[i].hw != 0 ? 8'h00 : rows[i].f1);
            wr(8'h00, 8'h00, 4'h0);
            {stby, sysRst, pin} = 3'h0;
            ram = 0;
            step(2);
            chk("program off", prog, 1'b0);
        end
        $display("table test done");
        boot = 1; modStby = 1;
        step(2);
        chk("irq boot", irqO, 1'b0);
        chk("nmi boot", nmiO, 1'b0);
        chk("access", accEn, 1'b0);
        chk("rom read", romRd, `MASK_ROM_READ);
        boot = 0; modStby = 0;
        step(2);
        chk("nmi", nmiO, 1'b1);
        chk("access on", accEn, 1'b1);
        $display("boot and module standby test done");
        for (int c = 0; c < 3; c++) begin
            powerOn();
            chk("reset flag", err, 1'b0);
            chk("reset access", accEn, 1'b1);
            f = c == 0 ? 8'h41 : 8'h42;
            wr(f, 8'h04, 4'h0);
            step(1);
            chk("nmi busy", nmiO, 1'b0);
            {slp, exc, rdAcc} = 3'b001 << c;
            step(1);
            {slp, exc, rdAcc} = 3'h0;
            chk("flag", err, 1'b1);
            chk("abort", {prog, ers}, 2'b00);
            chk("fc1 kept", regRd, f);
            wr(f, 8'h04, 4'h0);
            step(2);
            chk("restart", {prog, ers}, 2'b00);
            wr(c == 0 ? 8'h44 : 8'h48, 8'h04, 4'h0);
            step(2);
            chk("verify", {pv, ev}, c == 0 ? 2'b10 : 2'b01);
            rdSel = `SEL_FC2;
            step(1);
            chk("fc2", regRd, 8'h80);
            rdSel = `SEL_FC1;
            sysRst = 1;
            step(1);
            sysRst = 0;
            step(1);
            chk("flag kept", err, 1'b1);
            $display("error cause %0d test done", c);
        end
        powerOn();
        chk("flag cleared", err, 1'b0);
        $display("power-on clear test done");
        print_verdict();
    end
endmodule
`default_nettype wire
